// >>> core/hsq_regs.vh
// constants shared by the homing sequencer files
`ifndef HSQ_REGS_VH
`define HSQ_REGS_VH

// ****************************************************************
// phase word layout
// ****************************************************************
`define HSQ_PH_W 10
`define HSQ_PH_DIR 9
`define HSQ_PH_FAST 8
`define HSQ_PH_SEL_HI 7
`define HSQ_PH_SEL_LO 6
`define HSQ_PH_RISE 5
`define HSQ_PH_IDX 4
`define HSQ_PH_LAST 3
`define HSQ_PH_NEXT_HI 2
`define HSQ_PH_NEXT_LO 0

// ****************************************************************
// switch selectors inside a phase word
// ****************************************************************
`define HSQ_SEL_NEG 2'h0
`define HSQ_SEL_POS 2'h1
`define HSQ_SEL_REF 2'h2
`define HSQ_SEL_NONE 2'h3

// ****************************************************************
// method range and fixed steps
// ****************************************************************
`define HSQ_METHOD_MIN 8'h01
`define HSQ_METHOD_MAX 8'h0e
`define HSQ_MIRROR_FIRST 8'h0b
`define HSQ_MIRROR_OFFSET 8'h04
`define HSQ_LIMIT_FIRST 4'h7
`define HSQ_LIMIT_STEP 3'h7

// ****************************************************************
// input bit positions after synchronising
// ****************************************************************
`define HSQ_IN_NEG 0
`define HSQ_IN_POS 1
`define HSQ_IN_REF 2
`define HSQ_IN_IDX 3
`define HSQ_IN_W 4

// ****************************************************************
// error codes and reset values
// ****************************************************************
`define HSQ_ERR_NONE 4'h0
`define HSQ_ERR_METHOD 4'h1
`define HSQ_ERR_LIMIT 4'h2
`define HSQ_ERR_ABORT 4'h3
`define HSQ_RST_DIR 1'b0
`define HSQ_RST_ZERO 1'b1

`endif

// >>> core/hsq_input_sync.v
// two-stage synchroniser with registered edge detection
`timescale 1ns/100ps
`default_nettype none

module hsq_input_sync #(
	parameter WIDTH = 4
) (
	input wire i_clock,
	input wire i_rst,
	input wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_level,
	output wire [WIDTH-1:0] o_rise,
	output wire [WIDTH-1:0] o_fall
);

	// ****************************************************************
	// per-bit chain
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : bit_chain
			reg meta;
			reg stable;
			reg prev;
			// meta feeds only stable; edges come from stable vs prev
			always @(posedge i_clock or posedge i_rst) begin
				if (i_rst) begin
					meta <= 1'b0;
					stable <= 1'b0;
					prev <= 1'b0;
				end else begin
					meta <= i_async[g];
					stable <= meta;
					prev <= stable;
				end
			end
			assign o_level[g] = stable;
			assign o_rise[g] = stable & ~prev;
			assign o_fall[g] = ~stable & prev;
		end
	endgenerate

endmodule

`default_nettype wire

// >>> core/hsq_sequencer.v
// homing sequencer for switch and index based methods 1 to 14
`timescale 1ns/100ps
`default_nettype none
`include "hsq_regs.vh"

// Behaviour
// - method 1 homes on negative overtravel then index
// - method 2 mirrors method 1 on positive overtravel
// - method 3 reference switch, fast positive start
// - method 4 reference switch, slow positive start
// - method 5 reference switch, fast negative start
// - method 6 reference switch, slow negative start
// - methods 7 to 10 start moving positive
// - method 7 without limit hit sequence
// - method 7 reverses fast on positive overtravel
// - method 8 without limit hit sequence
// - method 8 after positive overtravel hit
// - method 9 without limit hit sequence
// - method 9 after positive overtravel hit
// - method 10 without limit hit sequence
// - method 10 after positive overtravel hit
// - methods 11 to 14 mirror 7 to 10
// - fast uses switch speed, slow uses zero speed
// - homing acceleration applies to every move
// - attained flag on success, error flag plus code
module hsq_sequencer #(
	parameter SPEED_W = 32,
	parameter POS_W = 32
) (
	input wire i_clock,
	input wire i_rst,
	input wire i_start,
	input wire i_abort,
	input wire [7:0] i_method,
	input wire i_negative_overtravel_switch,
	input wire i_pos_travel_limit_input,
	input wire i_reference_switch,
	input wire i_index_pulse,
	input wire [SPEED_W-1:0] i_switch_search_speed,
	input wire [SPEED_W-1:0] i_zero_search_speed,
	input wire [SPEED_W-1:0] i_homing_acceleration,
	input wire [POS_W-1:0] i_position,
	output reg o_busy,
	output reg o_dir_positive,
	output reg o_speed_fast,
	output reg o_velocity_zero,
	output reg [SPEED_W-1:0] o_speed_command,
	output reg [SPEED_W-1:0] o_accel_command,
	output reg o_homing_attained,
	output reg o_homing_error,
	output reg [3:0] o_error_code,
	output reg [POS_W-1:0] o_home_position
);

	// ****************************************************************
	// states
	// ****************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_RUN = 3'h1;
	localparam ST_STOP = 3'h2;
	localparam ST_DONE = 3'h3;
	localparam ST_ERR = 3'h4;

	localparam DIR_P = 1'b1;
	localparam DIR_N = 1'b0;
	localparam FAST = 1'b1;
	localparam SLOW = 1'b0;
	localparam RISE = 1'b1;
	localparam FALL = 1'b0;

	// ****************************************************************
	// phase table
	// ****************************************************************
	function [`HSQ_PH_W-1:0] ph;
		input dir;
		input fast;
		input [1:0] sel;
		input rise;
		input idx;
		input last;
		input [2:0] nxt;
		begin
			ph = {dir, fast, sel, rise, idx, last, nxt};
		end
	endfunction

	// one phase per step; step 7 is the overtravel reversal
	function [`HSQ_PH_W-1:0] plan;
		input [3:0] base;
		input [2:0] step;
		begin
			plan = ph(DIR_P, SLOW, `HSQ_SEL_NONE, RISE, 1'b1, 1'b1, 3'h0);
			case ({base, step})
				// fast to limit rise, slow back to index after fall
				{4'h1, 3'h0}: plan = ph(DIR_N, FAST, `HSQ_SEL_NEG, RISE, 1'b0, 1'b0, 3'h1);
				{4'h1, 3'h1}: plan = ph(DIR_P, SLOW, `HSQ_SEL_NEG, FALL, 1'b1, 1'b1, 3'h0);
				// positive limit counterpart
				{4'h2, 3'h0}: plan = ph(DIR_P, FAST, `HSQ_SEL_POS, RISE, 1'b0, 1'b0, 3'h1);
				{4'h2, 3'h1}: plan = ph(DIR_N, SLOW, `HSQ_SEL_POS, FALL, 1'b1, 1'b1, 3'h0);
				{4'h3, 3'h0}: plan = ph(DIR_P, FAST, `HSQ_SEL_REF, RISE, 1'b1, 1'b0, 3'h1);
				{4'h3, 3'h1}: plan = ph(DIR_N, SLOW, `HSQ_SEL_REF, FALL, 1'b1, 1'b1, 3'h0);
				{4'h4, 3'h0}: plan = ph(DIR_N, FAST, `HSQ_SEL_REF, FALL, 1'b1, 1'b0, 3'h1);
				{4'h4, 3'h1}: plan = ph(DIR_P, SLOW, `HSQ_SEL_REF, RISE, 1'b1, 1'b1, 3'h0);
				{4'h4, 3'h2}: plan = ph(DIR_P, SLOW, `HSQ_SEL_REF, FALL, 1'b1, 1'b1, 3'h0);
				{4'h5, 3'h0}: plan = ph(DIR_N, FAST, `HSQ_SEL_REF, RISE, 1'b1, 1'b0, 3'h1);
				{4'h5, 3'h1}: plan = ph(DIR_P, SLOW, `HSQ_SEL_REF, FALL, 1'b1, 1'b1, 3'h0);
				// return phase needs no new edge, falling edge already passed
				{4'h6, 3'h0}: plan = ph(DIR_P, FAST, `HSQ_SEL_REF, FALL, 1'b1, 1'b0, 3'h1);
				{4'h6, 3'h1}: plan = ph(DIR_N, SLOW, `HSQ_SEL_NONE, FALL, 1'b1, 1'b1, 3'h0);
				{4'h6, 3'h2}: plan = ph(DIR_N, SLOW, `HSQ_SEL_REF, RISE, 1'b1, 1'b1, 3'h0);
				{4'h7, 3'h0}: plan = ph(DIR_P, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h1);
				{4'h7, 3'h1}: plan = ph(DIR_N, SLOW, `HSQ_SEL_REF, FALL, 1'b1, 1'b1, 3'h0);
				// reversed fast, decelerate at rise, keep negative
				{4'h7, 3'h7}: plan = ph(DIR_N, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h1);
				{4'h8, 3'h0}: plan = ph(DIR_P, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h1);
				{4'h8, 3'h1}: plan = ph(DIR_P, SLOW, `HSQ_SEL_NONE, RISE, 1'b1, 1'b1, 3'h0);
				{4'h8, 3'h2}: plan = ph(DIR_N, SLOW, `HSQ_SEL_REF, FALL, 1'b0, 1'b0, 3'h3);
				{4'h8, 3'h3}: plan = ph(DIR_P, SLOW, `HSQ_SEL_REF, RISE, 1'b1, 1'b1, 3'h0);
				{4'h8, 3'h7}: plan = ph(DIR_N, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h2);
				{4'h9, 3'h0}: plan = ph(DIR_P, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h1);
				{4'h9, 3'h1}: plan = ph(DIR_P, SLOW, `HSQ_SEL_REF, FALL, 1'b0, 1'b0, 3'h2);
				{4'h9, 3'h2}: plan = ph(DIR_N, SLOW, `HSQ_SEL_REF, RISE, 1'b1, 1'b1, 3'h0);
				{4'h9, 3'h7}: plan = ph(DIR_N, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h3);
				{4'h9, 3'h3}: plan = ph(DIR_N, SLOW, `HSQ_SEL_NONE, RISE, 1'b1, 1'b1, 3'h0);
				{4'ha, 3'h0}: plan = ph(DIR_P, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h1);
				{4'ha, 3'h1}: plan = ph(DIR_P, SLOW, `HSQ_SEL_REF, FALL, 1'b1, 1'b1, 3'h0);
				{4'ha, 3'h7}: plan = ph(DIR_N, FAST, `HSQ_SEL_REF, RISE, 1'b0, 1'b0, 3'h1);
				default: plan = ph(DIR_P, SLOW, `HSQ_SEL_NONE, RISE, 1'b1, 1'b1, 3'h0);
			endcase
		end
	endfunction

	// first step depends on the start level of the watched switch
	function [2:0] first_step;
		input [3:0] base;
		input active;
		begin
			case (base)
				4'h4: first_step = active ? 3'h0 : 3'h2;
				4'h5: first_step = active ? 3'h1 : 3'h0;
				4'h6: first_step = active ? 3'h0 : 3'h2;
				4'h8: first_step = active ? 3'h2 : 3'h0;
				default: first_step = active ? 3'h1 : 3'h0;
			endcase
		end
	endfunction

	// ****************************************************************
	// input conditioning
	// ****************************************************************
	wire [`HSQ_IN_W-1:0] in_level;
	wire [`HSQ_IN_W-1:0] in_rise;
	wire [`HSQ_IN_W-1:0] in_fall;

	hsq_input_sync #(
		.WIDTH(`HSQ_IN_W)
	) u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async({i_index_pulse, i_reference_switch, i_pos_travel_limit_input,
			i_negative_overtravel_switch}),
		.o_level(in_level),
		.o_rise(in_rise),
		.o_fall(in_fall)
	);

	// ****************************************************************
	// sequencing state
	// ****************************************************************
	reg [2:0] state;
	reg [3:0] base;
	reg mirror;
	reg [2:0] step;
	reg armed;

	wire [`HSQ_PH_W-1:0] cur = plan(base, step);
	wire [1:0] cur_sel = cur[`HSQ_PH_SEL_HI:`HSQ_PH_SEL_LO];
	wire [2:0] cur_next = cur[`HSQ_PH_NEXT_HI:`HSQ_PH_NEXT_LO];
	// mirrored methods invert travel; limit swaps to negative side
	wire move_pos = cur[`HSQ_PH_DIR] ^ mirror;
	wire [1:0] sel_eff = (mirror && cur_sel == `HSQ_SEL_POS) ? `HSQ_SEL_NEG : cur_sel;

	wire [7:0] meth_base = (i_method >= `HSQ_MIRROR_FIRST) ?
		(i_method - `HSQ_MIRROR_OFFSET) : i_method;
	wire meth_ok = (i_method >= `HSQ_METHOD_MIN) && (i_method <= `HSQ_METHOD_MAX);
	wire start_active = (i_method == 8'h01) ? in_level[`HSQ_IN_NEG] :
		(i_method == 8'h02) ? in_level[`HSQ_IN_POS] : in_level[`HSQ_IN_REF];

	reg sw_edge;
	always @* begin
		case (sel_eff)
			`HSQ_SEL_NEG: sw_edge = cur[`HSQ_PH_RISE] ? in_rise[`HSQ_IN_NEG] : in_fall[`HSQ_IN_NEG];
			`HSQ_SEL_POS: sw_edge = cur[`HSQ_PH_RISE] ? in_rise[`HSQ_IN_POS] : in_fall[`HSQ_IN_POS];
			`HSQ_SEL_REF: sw_edge = cur[`HSQ_PH_RISE] ? in_rise[`HSQ_IN_REF] : in_fall[`HSQ_IN_REF];
			default: sw_edge = 1'b0;
		endcase
	end

	// overtravel reached in the opening fast search of methods 7 to 14
	wire lim_mode = (base >= `HSQ_LIMIT_FIRST);
	wire travel_lim_rise = mirror ? in_rise[`HSQ_IN_NEG] : in_rise[`HSQ_IN_POS];
	wire lim_reverse = lim_mode && step == 3'h0 && travel_lim_rise;
	// any other limit hit in the direction of travel is a failure, unless that limit is the switch searched before arming
	wire bad_limit = (move_pos ? in_rise[`HSQ_IN_POS] : in_rise[`HSQ_IN_NEG]) &&
		!(sel_eff == (move_pos ? `HSQ_SEL_POS : `HSQ_SEL_NEG) && !armed);
	wire idx_hit = armed && in_rise[`HSQ_IN_IDX];

	reg [2:0] next_state;
	reg [2:0] next_step;
	reg next_armed;
	reg [3:0] next_err;

	always @* begin
		next_state = state;
		next_step = step;
		next_armed = armed;
		next_err = o_error_code;
		case (state)
			ST_IDLE, ST_DONE, ST_ERR: begin
				if (i_start) begin
					if (meth_ok) begin
						next_state = ST_STOP;
						next_err = `HSQ_ERR_NONE;
						next_step = first_step(meth_base[3:0], start_active);
					end else begin
						next_state = ST_ERR;
						next_err = `HSQ_ERR_METHOD;
					end
				end
			end
			ST_RUN: begin
				if (i_abort) begin
					next_state = ST_ERR;
					next_err = `HSQ_ERR_ABORT;
				end else if (lim_reverse) begin
					// reversal beats the generic limit
					next_state = ST_STOP;
					next_step = `HSQ_LIMIT_STEP;
				end else if (bad_limit) begin
					next_state = ST_ERR;
					next_err = `HSQ_ERR_LIMIT;
				end else if (!armed && sw_edge) begin
					// an edge alone ends a phase without index search
					if (cur[`HSQ_PH_IDX]) begin
						next_armed = 1'b1;
					end else begin
						next_state = ST_STOP;
						next_step = cur_next;
					end
				end else if (idx_hit) begin
					if (cur[`HSQ_PH_LAST]) begin
						next_state = ST_DONE;
					end else begin
						next_state = ST_STOP;
						next_step = cur_next;
					end
				end
			end
			ST_STOP: begin
				// one cycle at zero velocity between phases
				next_state = ST_RUN;
				next_armed = (sel_eff == `HSQ_SEL_NONE);
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
			base <= 4'h0;
			mirror <= 1'b0;
			step <= 3'h0;
			armed <= 1'b0;
		end else begin
			state <= next_state;
			step <= next_step;
			armed <= next_armed;
			if ((state == ST_IDLE || state == ST_DONE || state == ST_ERR) && i_start && meth_ok) begin
				base <= meth_base[3:0];
				mirror <= (i_method >= `HSQ_MIRROR_FIRST);
			end
		end
	end

	// ****************************************************************
	// outputs toward the motion generator
	// ****************************************************************
	// direction and speed level lag the phase by one cycle; stops stay safe since zero is forced
	always @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_busy <= 1'b0;
			o_dir_positive <= `HSQ_RST_DIR;
			o_speed_fast <= 1'b0;
			o_velocity_zero <= `HSQ_RST_ZERO;
			o_speed_command <= {SPEED_W{1'b0}};
			o_accel_command <= {SPEED_W{1'b0}};
			o_homing_attained <= 1'b0;
			o_homing_error <= 1'b0;
			o_error_code <= `HSQ_ERR_NONE;
			o_home_position <= {POS_W{1'b0}};
		end else begin
			o_busy <= (next_state == ST_RUN) || (next_state == ST_STOP);
			o_dir_positive <= move_pos;
			o_speed_fast <= cur[`HSQ_PH_FAST];
			o_velocity_zero <= (next_state != ST_RUN);
			if (next_state != ST_RUN) begin
				o_speed_command <= {SPEED_W{1'b0}};
			end else if (cur[`HSQ_PH_FAST]) begin
				o_speed_command <= i_switch_search_speed;
			end else begin
				o_speed_command <= i_zero_search_speed;
			end
			o_accel_command <= i_homing_acceleration;
			o_homing_attained <= (next_state == ST_DONE);
			o_homing_error <= (next_state == ST_ERR);
			o_error_code <= next_err;
			if (state == ST_RUN && next_state == ST_DONE) begin
				o_home_position <= i_position;
			end
		end
	end

endmodule

`default_nettype wire

// >>> dv/hsq_axis_model.sv
// behavioural axis: switches and encoder index follow a moving position
`timescale 1ns/100ps
`default_nettype none

module hsq_axis_model (
	input wire logic i_clock,
	input wire logic i_load,
	input wire logic signed [31:0] i_load_pos,
	input wire logic signed [31:0] i_ref_lo,
	input wire logic signed [31:0] i_ref_hi,
	input wire logic i_dir_positive,
	input wire logic i_velocity_zero,
	output logic o_neg_limit,
	output logic o_pos_limit,
	output logic o_ref,
	output logic o_index,
	output logic [31:0] o_pos
);
	// one count a clock at either speed: speed level is judged at the ports
	logic signed [31:0] pos = 32'sh0;
	always @(negedge i_clock) begin
		if (i_load) begin
			pos <= i_load_pos;
		end else if (!i_velocity_zero) begin
			pos <= i_dir_positive ? pos + 32'sh1 : pos - 32'sh1;
		end
	end
	assign o_neg_limit = pos < 32'sh64;
	assign o_pos_limit = pos > 32'sh384;
	assign o_ref = (pos >= i_ref_lo) && (pos <= i_ref_hi);
	// index mark every 32 counts
	assign o_index = pos[4:0] == 5'h0;
	assign o_pos = pos;
endmodule

`default_nettype wire

// >>> dv/hsq_sequencer_chk.sv
// port assertions for the homing sequencer
`timescale 1ns/100ps
`default_nettype none

module hsq_sequencer_chk #(
	parameter SPEED_W = 32,
	parameter POS_W = 32
) (
	input wire i_clock,
	input wire i_rst,
	input wire i_start,
	input wire [7:0] i_method,
	input wire i_reference_switch,
	input wire [SPEED_W-1:0] i_switch_search_speed,
	input wire [SPEED_W-1:0] i_zero_search_speed,
	input wire [SPEED_W-1:0] i_homing_acceleration,
	input wire [POS_W-1:0] i_position,
	input wire o_busy,
	input wire o_dir_positive,
	input wire o_speed_fast,
	input wire o_velocity_zero,
	input wire [SPEED_W-1:0] o_speed_command,
	input wire [SPEED_W-1:0] o_accel_command,
	input wire o_homing_attained,
	input wire o_homing_error,
	input wire [3:0] o_error_code,
	input wire [POS_W-1:0] o_home_position
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	chk_stop_speed: assert property (
		o_velocity_zero |-> o_speed_command == '0) else $error("speed not zero at stop");
	chk_fast_speed: assert property (
		o_busy && !o_velocity_zero && o_speed_fast |-> o_speed_command == i_switch_search_speed)
		else $error("fast phase speed wrong");
	chk_slow_speed: assert property (
		o_busy && !o_velocity_zero && !o_speed_fast |-> o_speed_command == i_zero_search_speed)
		else $error("slow phase speed wrong");
	chk_accel_pass: assert property (
		!$past(i_rst) |-> o_accel_command == $past(i_homing_acceleration))
		else $error("acceleration not passed on");
	chk_start_stop: assert property (
		i_start && !o_busy && i_method >= 8'h01 && i_method <= 8'h0e
		|=> o_busy && o_velocity_zero && !o_homing_attained) else $error("start not taken");
	chk_bad_method: assert property (
		i_start && !o_busy && (i_method == 8'h00 || i_method > 8'h0e)
		|=> o_homing_error && o_error_code == 4'h1 && !o_busy) else $error("bad method passed");
	chk_done_flags: assert property (
		$rose(o_homing_attained) |-> !o_busy && o_velocity_zero && !o_homing_error)
		else $error("done flags wrong");
	chk_home_latch: assert property (
		$rose(o_homing_attained) |-> o_home_position == $past(i_position))
		else $error("home position not latched");
	chk_start_pos: assert property (
		i_start && !o_busy && !i_reference_switch && i_method >= 8'h07 && i_method <= 8'h0a
		|-> ##3 o_dir_positive) else $error("first move not positive");
	chk_start_neg: assert property (
		i_start && !o_busy && !i_reference_switch && i_method >= 8'h0b && i_method <= 8'h0e
		|-> ##3 !o_dir_positive) else $error("first move not negative");
endmodule

bind hsq_sequencer hsq_sequencer_chk #(.SPEED_W(SPEED_W), .POS_W(POS_W)) u_chk (
	.i_clock(i_clock), .i_rst(i_rst), .i_start(i_start), .i_method(i_method),
	.i_reference_switch(i_reference_switch), .i_switch_search_speed(i_switch_search_speed),
	.i_zero_search_speed(i_zero_search_speed), .i_homing_acceleration(i_homing_acceleration),
	.i_position(i_position), .o_busy(o_busy), .o_dir_positive(o_dir_positive),
	.o_speed_fast(o_speed_fast), .o_velocity_zero(o_velocity_zero),
	.o_speed_command(o_speed_command), .o_accel_command(o_accel_command),
	.o_homing_attained(o_homing_attained), .o_homing_error(o_homing_error),
	.o_error_code(o_error_code), .o_home_position(o_home_position)
);

`default_nettype wire

// >>> dv/homing_sequencer_switch_index_tb.sv
// self-checking bench for the homing sequencer with an axis model
`timescale 1ns/100ps
`default_nettype none

module homing_sequencer_switch_index_tb;
	logic i_clock, i_rst, i_start, i_abort, ld;
	logic [7:0] i_method;
	logic [31:0] i_accel, o_spd, o_acc, o_home;
	logic signed [31:0] ld_pos, rlo, rhi;
	logic o_busy, o_dir, o_fast, o_vz, o_att, o_err;
	logic [3:0] o_code;
	wire logic neg, plim, refs, idx;
	wire logic [31:0] position;
	int error_cnt, total_checks;

	hsq_sequencer dut (.i_clock(i_clock), .i_rst(i_rst), .i_start(i_start),
		.i_abort(i_abort), .i_method(i_method), .i_negative_overtravel_switch(neg),
		.i_pos_travel_limit_input(plim), .i_reference_switch(refs), .i_index_pulse(idx),
		.i_switch_search_speed(32'd5000), .i_zero_search_speed(32'd100),
		.i_homing_acceleration(i_accel), .i_position(position), .o_busy(o_busy),
		.o_dir_positive(o_dir), .o_speed_fast(o_fast), .o_velocity_zero(o_vz),
		.o_speed_command(o_spd), .o_accel_command(o_acc), .o_homing_attained(o_att),
		.o_homing_error(o_err), .o_error_code(o_code), .o_home_position(o_home));
	hsq_axis_model axis (.i_clock(i_clock), .i_load(ld), .i_load_pos(ld_pos),
		.i_ref_lo(rlo), .i_ref_hi(rhi), .i_dir_positive(o_dir), .i_velocity_zero(o_vz),
		.o_neg_limit(neg), .o_pos_limit(plim), .o_ref(refs), .o_index(idx), .o_pos(position));

	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// home position rounded to the nearest index mark: overshoot is a few counts
	task automatic home_run(input logic [7:0] m, input int st, lo, hi,
		input logic d, f, input int home);
		int n;
		ld <= 1'b1;
		ld_pos <= st;
		rlo <= lo;
		rhi <= hi;
		i_accel <= i_accel + 32'h1;
		@(negedge i_clock);
		ld <= 1'b0;
		repeat (5) @(negedge i_clock);
		i_start <= 1'b1;
		i_method <= m;
		@(negedge i_clock);
		i_start <= 1'b0;
		repeat (2) @(negedge i_clock);
		check(32'(o_dir), 32'(d));
		check(32'(o_fast), 32'(f));
		n = 0;
		while (o_att !== 1'b1 && o_err !== 1'b1 && n < 6000) begin
			@(negedge i_clock);
			n++;
		end
		check(32'(o_att), 32'h1);
		check(32'(o_busy), 32'h0);
		check(32'(o_vz), 32'h1);
		check((o_home + 32'h10) & ~32'h1f, 32'(home));
		$display("method %0d from %0d done", m, st);
	endtask

	task automatic t_limits();
		home_run(8'h01, 300, 2000, 2000, 1'b0, 1'b1, 128);
		home_run(8'h01, 50, 2000, 2000, 1'b1, 1'b0, 128);
		home_run(8'h02, 500, 2000, 2000, 1'b1, 1'b1, 896);
		home_run(8'h02, 950, 2000, 2000, 1'b0, 1'b0, 896);
	endtask

	task automatic t_ref_half();
		home_run(8'h03, 300, 500, 5000, 1'b1, 1'b1, 480);
		home_run(8'h03, 700, 500, 5000, 1'b0, 1'b0, 480);
		home_run(8'h04, 700, 500, 5000, 1'b0, 1'b1, 512);
		home_run(8'h05, 300, -5000, 500, 1'b1, 1'b0, 512);
		home_run(8'h05, 700, -5000, 500, 1'b0, 1'b1, 512);
		home_run(8'h06, 700, -5000, 500, 1'b0, 1'b0, 480);
		home_run(8'h06, 300, -5000, 500, 1'b1, 1'b1, 512);
	endtask

	task automatic t_ref_window();
		home_run(8'h07, 200, 400, 600, 1'b1, 1'b1, 384);
		home_run(8'h07, 700, 400, 600, 1'b1, 1'b1, 384);
		home_run(8'h08, 200, 400, 600, 1'b1, 1'b1, 416);
		home_run(8'h09, 200, 400, 600, 1'b1, 1'b1, 576);
		home_run(8'h09, 700, 400, 600, 1'b1, 1'b1, 576);
		home_run(8'h0a, 200, 400, 600, 1'b1, 1'b1, 608);
		home_run(8'h0a, 700, 400, 600, 1'b1, 1'b1, 608);
	endtask

	task automatic t_mirror();
		home_run(8'h0b, 800, 400, 600, 1'b0, 1'b1, 608);
		home_run(8'h0b, 300, 400, 600, 1'b0, 1'b1, 608);
		home_run(8'h0c, 800, 400, 600, 1'b0, 1'b1, 576);
		home_run(8'h0d, 800, 400, 600, 1'b0, 1'b1, 416);
		home_run(8'h0e, 800, 400, 600, 1'b0, 1'b1, 384);
	endtask

	task automatic t_bad_method();
		logic [7:0] bad [2] = '{8'h00, 8'h0f};
		foreach (bad[k]) begin
			i_start <= 1'b1;
			i_method <= bad[k];
			@(negedge i_clock);
			i_start <= 1'b0;
			repeat (2) @(negedge i_clock);
			check(32'(o_err), 32'h1);
			check(32'(o_code), 32'h1);
			check(32'(o_busy), 32'h0);
		end
		$display("bad method done");
	endtask

	// a start while running must be ignored, so the abort code survives
	task automatic t_abort();
		i_start <= 1'b1;
		i_method <= 8'h02;
		@(negedge i_clock);
		i_start <= 1'b0;
		repeat (20) @(negedge i_clock);
		i_start <= 1'b1;
		i_method <= 8'h00;
		@(negedge i_clock);
		i_start <= 1'b0;
		i_abort <= 1'b1;
		repeat (3) @(negedge i_clock);
		i_abort <= 1'b0;
		check(32'(o_err), 32'h1);
		check(32'(o_code), 32'h3);
		check(32'(o_vz), 32'h1);
		$display("abort done");
	endtask

	// reference never met: the run ends on the positive limit with code 2
	task automatic t_limit_error();
		ld <= 1'b1;
		ld_pos <= 300;
		rlo <= 2000;
		rhi <= 2000;
		@(negedge i_clock);
		ld <= 1'b0;
		repeat (5) @(negedge i_clock);
		i_start <= 1'b1;
		i_method <= 8'h03;
		@(negedge i_clock);
		i_start <= 1'b0;
		repeat (700) @(negedge i_clock);
		check(32'(o_err), 32'h1);
		check(32'(o_code), 32'h2);
		check(32'(o_busy), 32'h0);
		check(32'(o_vz), 32'h1);
		$display("limit error done");
	endtask

	// longest path is 23 runs of under 2000 clocks
	initial begin
		repeat (90000) @(posedge i_clock);
		error_cnt++;
		test_done();
	end

	initial begin
		i_rst = 1'b1;
		i_start = 1'b0;
		i_abort = 1'b0;
		i_method = 8'h01;
		i_accel = 32'd100000;
		ld = 1'b0;
		ld_pos = 32'sh0;
		rlo = 32'sh7d0;
		rhi = 32'sh7d0;
		repeat (8) @(negedge i_clock);
		i_rst <= 1'b0;
		t_limits();
		t_ref_half();
		t_ref_window();
		t_mirror();
		t_bad_method();
		t_abort();
		t_limit_error();
		test_done();
	end
endmodule

`default_nettype wire
